// ---- hw/vic_regs.svh ----
// register offsets, field positions, reset values and vector table of the
// vectored interrupt controller; assumes a 32-bit avalon-mm word map
`ifndef VIC_REGS_SVH
`define VIC_REGS_SVH

`define VIC_OFS_MASK      4'h0
`define VIC_OFS_PRIO      4'h4
`define VIC_OFS_PEND      4'h8
`define VIC_OFS_SYSMODE   4'hC

`define VIC_SYM_GIE       0
`define VIC_SYM_FIE       1
`define VIC_SYM_FSEL_LO   2
`define VIC_SYM_TRI       7
`define VIC_SYM_WMASK     8'h9F

`define VIC_RST_MASK      8'h00
`define VIC_RST_PRIO      8'h00
`define VIC_RST_SYSMODE   8'h00
`define VIC_RESET_VECTOR  16'h0100

`define VIC_VEC_T0_MC     8'hFC
`define VIC_VEC_T0_OV     8'hFA
`define VIC_VEC_T1_MC     8'hF6
`define VIC_VEC_T1_OV     8'hF4
`define VIC_VEC_T2_MC     8'hF2
`define VIC_VEC_T2_OV     8'hF0
`define VIC_VEC_CNTA      8'hEC
`define VIC_VEC_P0_HI     8'hE8
`define VIC_VEC_P0_LO0    8'hE0
`define VIC_VEC_P2_HI     8'hD8
`define VIC_VEC_P2_LO0    8'hD0

`endif

// ---- hw/vic_pkg.sv ----
// types of the vectored interrupt controller
package vic_pkg;
    typedef enum logic [1:0] {
        VIC_IDLE  = 2'b00,
        VIC_FETCH = 2'b01,
        VIC_SERVE = 2'b10
    } vic_state_t;

    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } vic_bus_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } vic_bus_rsp_t;

    typedef struct packed {
        vic_state_t  state;
        logic [7:0]  mask;
        logic [7:0]  prio;
        logic [7:0]  sysmode;
        logic [23:0] src_pend;
        logic [31:0] readdata;
        logic        ack;
        logic        irq;
        logic [7:0]  vec;
        logic [2:0]  level;
        logic [4:0]  src;
        logic [15:0] rom_addr;
        logic        rom_rd;
        logic [7:0]  svc_hi;
        logic [15:0] svc_addr;
        logic        svc_valid;
        logic        boot_taken;
        logic [15:0] boot_addr;
    } vic_state_s_t;
endpackage : vic_pkg

// ---- hw/vic_top.sv ----
// vectored interrupt controller: level pending, mask, group priority,
// in-level ordering, vector fetch from the rom vector area and reset vector.
// assumes sources pulse one cycle from the same clock; the cpu raises
// i_cpu_accept when it takes the request, and rom data must be valid in the same cycle as o_rom_rd.
// Functional notes
// - vectors fetched from rom locations 00h to FFh
// - reset start address 0100h, boot word relocates
// - reset event above levels, hardware clears it
// - timer vectors fixed, overflow beats match
// - counter a on level 2, vector ECh
// - port 0 pins on levels 7 and 6
// - port 2 pins on levels 5 and 4
// - lower in-level rank number wins
// - fixed hardware order, lowest vector first
// - enable instruction sets global enable
// - disable instruction clears global enable anytime
// - global enable is system mode bit 0
// - level mask bit per level, read/write
// - priority register orders groups a, b, c
// - read-only pending bit per level
// - on accept disable, fetch 16-bit service address
// - reset clears enable, fast, interface bits
`timescale 1ns/1ns
`include "vic_regs.svh"
module vic_top
    import vic_pkg::*;
(
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst,
    input  wire vic_bus_req_t i_bus,
    output vic_bus_rsp_t      o_bus,
    input  wire logic [23:0]  i_src_req,
    input  wire logic [23:0]  i_src_clr,
    input  wire logic         i_ei_exec,
    input  wire logic         i_di_exec,
    input  wire logic         i_boot_reset,
    input  wire logic [15:0]  i_boot_vector,
    input  wire logic         i_cpu_accept,
    input  wire logic [7:0]   i_rom_data,
    output logic              o_irq,
    output logic [2:0]        o_irq_level,
    output logic [7:0]        o_vector,
    output logic [15:0]       o_rom_addr,
    output logic              o_rom_rd,
    output logic [15:0]       o_svc_addr,
    output logic              o_svc_valid,
    output logic [15:0]       o_reset_addr,
    output logic              o_ext_tristate
);
    // source index map: 0 t0 mc, 1 t0 ov, 2 t1 mc, 3 t1 ov, 4 cnt a,
    // 5 t2 mc, 6 t2 ov, 7..10 p0.0..p0.3, 11..14 p0.4..p0.7,
    // 15..18 p2.0..p2.3, 19..22 p2.4..p2.7, 23 unused
    localparam logic [23:0] HW_CLEAR = 24'h00004A;

    vic_state_s_t s_q;
    vic_state_s_t s_d;

    function automatic logic [2:0] src_level(input logic [4:0] i);
        if (i <= 5'd1) src_level = 3'd0;
        else if (i <= 5'd3) src_level = 3'd1;
        else if (i == 5'd4) src_level = 3'd2;
        else if (i <= 5'd6) src_level = 3'd3;
        else if (i <= 5'd10) src_level = 3'd6;
        else if (i <= 5'd14) src_level = 3'd7;
        else if (i <= 5'd18) src_level = 3'd4;
        else src_level = 3'd5;
    endfunction : src_level

    function automatic logic [7:0] src_vector(input logic [4:0] i);
        unique case (i)
            5'd0: src_vector = `VIC_VEC_T0_MC;
            5'd1: src_vector = `VIC_VEC_T0_OV;
            5'd2: src_vector = `VIC_VEC_T1_MC;
            5'd3: src_vector = `VIC_VEC_T1_OV;
            5'd4: src_vector = `VIC_VEC_CNTA;
            5'd5: src_vector = `VIC_VEC_T2_MC;
            5'd6: src_vector = `VIC_VEC_T2_OV;
            5'd7, 5'd8, 5'd9, 5'd10:
                src_vector = `VIC_VEC_P0_LO0 + {4'h0, 2'(i - 5'd7), 1'b0};
            5'd11, 5'd12, 5'd13, 5'd14: src_vector = `VIC_VEC_P0_HI;
            5'd15, 5'd16, 5'd17, 5'd18:
                src_vector = `VIC_VEC_P2_LO0 + {4'h0, 2'(i - 5'd15), 1'b0};
            default: src_vector = `VIC_VEC_P2_HI;
        endcase
    endfunction : src_vector

    // group order from the priority register: bits [2:0] choose among
    // groups (0 a>b>c, 1 b>c>a, 2 a>c>b, 3 c>a>b, 4 b>a>c, 5 c>b>a),
    // bit 3 swaps within a, bit 4 swaps within b, bit 5 swaps within c
    function automatic logic [2:0] grp_rank(input logic [7:0] p, input logic [1:0] g);
        logic [5:0] ord;
        ord = 6'b100100;
        unique case (p[2:0])
            3'd1:    ord = {2'd1, 2'd0, 2'd2};
            3'd2:    ord = {2'd1, 2'd2, 2'd0};
            3'd3:    ord = {2'd0, 2'd2, 2'd1};
            3'd4:    ord = {2'd2, 2'd0, 2'd1};
            3'd5:    ord = {2'd0, 2'd1, 2'd2};
            default: ord = {2'd2, 2'd1, 2'd0};
        endcase
        grp_rank = {1'b0, ord[g*2 +: 2]};
    endfunction : grp_rank

    function automatic logic [1:0] lvl_group(input logic [2:0] l);
        if (l <= 3'd1) lvl_group = 2'd0;
        else if (l <= 3'd4) lvl_group = 2'd1;
        else lvl_group = 2'd2;
    endfunction : lvl_group

    // rank key: group rank, then position in group, smaller wins
    function automatic logic [5:0] lvl_key(input logic [7:0] p, input logic [2:0] l);
        logic [2:0] pos;
        pos = 3'd0;
        unique case (l)
            3'd0: pos = p[3] ? 3'd1 : 3'd0;
            3'd1: pos = p[3] ? 3'd0 : 3'd1;
            3'd2: pos = p[4] ? 3'd2 : 3'd0;
            3'd3: pos = 3'd1;
            3'd4: pos = p[4] ? 3'd0 : 3'd2;
            3'd5: pos = p[5] ? 3'd2 : 3'd0;
            3'd6: pos = 3'd1;
            default: pos = p[5] ? 3'd0 : 3'd2;
        endcase
        lvl_key = {grp_rank(p, lvl_group(l)), pos};
    endfunction : lvl_key

    logic [7:0]  lvl_pend;
    logic [7:0]  lvl_ok;
    logic [4:0]  win_src [8];
    logic        win_any;
    logic [2:0]  win_lvl;
    logic [5:0]  win_key;

    always_comb begin
        lvl_pend = 8'h00;
        for (int k = 0; k < 8; k++) win_src[k] = 5'd0;
        // in-level winner is lowest vector; scan from highest index down
        for (int i = 22; i >= 0; i--) begin
            if (s_q.src_pend[i]) begin
                lvl_pend[src_level(5'(i))] = 1'b1;
                if (!lvl_pend[src_level(5'(i))] ||
                    src_vector(5'(i)) <= src_vector(win_src[src_level(5'(i))])) begin
                    win_src[src_level(5'(i))] = 5'(i);
                end
            end
        end
        for (int i = 22; i >= 0; i--) begin
            if (s_q.src_pend[i] &&
                src_vector(5'(i)) <= src_vector(win_src[src_level(5'(i))])) begin
                win_src[src_level(5'(i))] = 5'(i);
            end
        end
        lvl_ok = lvl_pend & s_q.mask & {8{s_q.sysmode[`VIC_SYM_GIE]}};
        win_any = |lvl_ok;
        win_lvl = 3'd0;
        win_key = 6'h3F;
        for (int l = 0; l < 8; l++) begin
            if (lvl_ok[l] && lvl_key(s_q.prio, 3'(l)) < win_key) begin
                win_key = lvl_key(s_q.prio, 3'(l));
                win_lvl = 3'(l);
            end
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.rom_rd = 1'b0;
        s_d.svc_valid = 1'b0;
        // hardware sets win over software clears
        s_d.src_pend = (s_q.src_pend & ~i_src_clr) | i_src_req;
        s_d.src_pend[23] = 1'b0;
        if (!s_q.boot_taken) begin
            s_d.boot_taken = 1'b1;
            s_d.boot_addr = i_boot_reset ? i_boot_vector : `VIC_RESET_VECTOR;
        end
        // write lands at the edge where waitrequest is seen low
        if (i_bus.write && s_q.ack) begin
            unique case (i_bus.address)
                `VIC_OFS_MASK: s_d.mask = i_bus.writedata[7:0];
                `VIC_OFS_PRIO: s_d.prio = i_bus.writedata[7:0];
                `VIC_OFS_SYSMODE: s_d.sysmode = i_bus.writedata[7:0] & `VIC_SYM_WMASK;
                default: ;
            endcase
        end
        if (i_bus.read && !s_q.ack) begin
            unique case (i_bus.address)
                `VIC_OFS_MASK: s_d.readdata = {24'h0, s_q.mask};
                `VIC_OFS_PRIO: s_d.readdata = {24'h0, s_q.prio};
                `VIC_OFS_PEND: s_d.readdata = {24'h0, lvl_pend};
                `VIC_OFS_SYSMODE: s_d.readdata = {24'h0, s_q.sysmode};
                default: s_d.readdata = 32'h0;
            endcase
        end
        s_d.ack = (i_bus.read || i_bus.write) && !s_q.ack;
        if (i_ei_exec) s_d.sysmode[`VIC_SYM_GIE] = 1'b1;
        if (i_di_exec) s_d.sysmode[`VIC_SYM_GIE] = 1'b0;
        unique case (s_q.state)
            VIC_IDLE: begin
                s_d.irq = win_any && !i_di_exec;
                s_d.level = win_lvl;
                s_d.src = win_src[win_lvl];
                s_d.vec = src_vector(win_src[win_lvl]);
                if (s_q.irq && i_cpu_accept) begin
                    s_d.irq = 1'b0;
                    s_d.sysmode[`VIC_SYM_GIE] = 1'b0;
                    s_d.src_pend[s_q.src] = i_src_req[s_q.src] |
                        (s_d.src_pend[s_q.src] & ~HW_CLEAR[s_q.src]);
                    s_d.rom_addr = {8'h00, s_q.vec};
                    s_d.rom_rd = 1'b1;
                    s_d.state = VIC_FETCH;
                end
            end
            VIC_FETCH: begin
                s_d.svc_hi = i_rom_data;
                s_d.rom_addr = {8'h00, s_q.vec + 8'h01};
                s_d.rom_rd = 1'b1;
                s_d.state = VIC_SERVE;
            end
            default: begin
                s_d.svc_addr = {s_q.svc_hi, i_rom_data};
                s_d.svc_valid = 1'b1;
                s_d.state = VIC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
            s_q.state <= VIC_IDLE;
            s_q.mask <= `VIC_RST_MASK;
            s_q.prio <= `VIC_RST_PRIO;
            s_q.sysmode <= `VIC_RST_SYSMODE;
            s_q.boot_addr <= `VIC_RESET_VECTOR;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_bus.readdata = s_q.readdata;
    assign o_bus.waitrequest = !s_q.ack;
    assign o_irq = s_q.irq;
    assign o_irq_level = s_q.level;
    assign o_vector = s_q.vec;
    assign o_rom_addr = s_q.rom_addr;
    assign o_rom_rd = s_q.rom_rd;
    assign o_svc_addr = s_q.svc_addr;
    assign o_svc_valid = s_q.svc_valid;
    assign o_reset_addr = s_q.boot_addr;
    assign o_ext_tristate = 1'b0 & s_q.sysmode[`VIC_SYM_TRI];
endmodule : vic_top

// ---- verification/vic_assertions.sv ----
// port checker of the interrupt controller
// bound into vic_top, one clock domain
`timescale 1ns/1ns
module vic_assertions
    import vic_pkg::*;
(
    input wire logic         i_sys_clk,
    input wire logic         i_rst,
    input wire vic_bus_req_t i_bus,
    input wire vic_bus_rsp_t o_bus,
    input wire logic         i_di_exec,
    input wire logic         i_cpu_accept,
    input wire logic         o_irq,
    input wire logic         o_rom_rd,
    input wire logic [15:0]  o_rom_addr,
    input wire logic         o_svc_valid,
    input wire logic         o_ext_tristate
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    property p_area; o_rom_rd |-> o_rom_addr[15:8] == 8'h00; endproperty
    a_area: assert property (p_area) else $error("rom read outside vectors");
    property p_fetch; o_irq && i_cpu_accept |-> ##[1:8] o_svc_valid; endproperty
    a_fetch: assert property (p_fetch) else $error("no service address");
    property p_svc; o_svc_valid |=> !o_svc_valid; endproperty
    a_svc: assert property (p_svc) else $error("service strobe too long");
    property p_take; o_irq && i_cpu_accept |-> ##2 !o_irq; endproperty
    a_take: assert property (p_take) else $error("request kept after accept");
    property p_di; i_di_exec |-> ##2 !o_irq; endproperty
    a_di: assert property (p_di) else $error("request after disable");
    property p_tri; !o_ext_tristate; endproperty
    a_tri: assert property (p_tri) else $error("interface tristated");
    property p_rd; $rose(i_bus.read) |=> !o_bus.waitrequest; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_wr; $rose(i_bus.write) |=> !o_bus.waitrequest; endproperty
    a_wr: assert property (p_wr) else $error("write not answered");
    property p_ack; !o_bus.waitrequest |=> o_bus.waitrequest; endproperty
    a_ack: assert property (p_ack) else $error("answer too long");
endmodule : vic_assertions
bind vic_top vic_assertions u_vic_assertions (.i_sys_clk, .i_rst, .i_bus, .o_bus, .i_di_exec,
    .i_cpu_accept, .o_irq, .o_rom_rd, .o_rom_addr, .o_svc_valid, .o_ext_tristate);

// ---- verification/vic_cpu_model.sv ----
// cpu core model: takes a request after i_delay cycles, serves rom bytes
// rom answers at once: the byte stands while the read strobe stands
`timescale 1ns/1ns
module vic_cpu_model (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic [3:0]  i_delay,
    input  wire logic        i_irq,
    input  wire logic        i_rom_rd,
    input  wire logic [15:0] i_rom_addr,
    input  wire logic        i_svc_valid,
    output logic             o_accept,
    output logic [7:0]       o_rom_data
);
    logic [3:0] wait_q;
    logic       busy_q;
    // idle rom shows the inverse of the addressed byte
    assign o_rom_data = i_rom_rd ? (i_rom_addr[7:0] ^ 8'hA5) : ~(i_rom_addr[7:0] ^ 8'hA5);
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_q <= 4'h0;
            busy_q <= 1'b0;
            o_accept <= 1'b0;
        end else begin
            o_accept <= 1'b0;
            if (i_svc_valid) busy_q <= 1'b0;
            if (i_irq && !busy_q) begin
                wait_q <= wait_q + 4'h1;
                if (wait_q >= i_delay) begin
                    o_accept <= 1'b1;
                    busy_q <= 1'b1;
                    wait_q <= 4'h0;
                end
            end
        end
    end
endmodule : vic_cpu_model

// ---- verification/vectored_interrupt_controller_bench.sv ----
// self-checking bench of the interrupt controller
// drives bus, sources and cpu pulses; the cpu model answers requests
`timescale 1ns/1ns
module vectored_interrupt_controller_bench;
    import vic_pkg::*;
    logic i_sys_clk, i_rst, ei, di, boot, acc, o_irq, rrd, sv, ext;
    vic_bus_req_t bq;
    vic_bus_rsp_t rsp;
    logic [23:0] req, clr;
    logic [15:0] bvec, raddr, svc, rsta;
    logic [7:0] vec, rdat;
    logic [2:0] lvl;
    logic [3:0] dly;
    logic [31:0] seed, rd, r;
    int n_fail, samples_checked, best, L, ia, ib, wl, wv;
    logic [7:0] vt [23] = '{8'hFC, 8'hFA, 8'hF6, 8'hF4, 8'hEC, 8'hF2, 8'hF0, 8'hE0, 8'hE2,
        8'hE4, 8'hE6, 8'hE8, 8'hE8, 8'hE8, 8'hE8, 8'hD0, 8'hD2, 8'hD4, 8'hD6, 8'hD8, 8'hD8,
        8'hD8, 8'hD8};
    int lv [23] = '{0, 0, 1, 1, 2, 3, 3, 6, 6, 6, 6, 7, 7, 7, 7, 4, 4, 4, 4, 5, 5, 5, 5};
    // rank of groups a, b, c for each group order code
    int gr [8][3] = '{'{0, 1, 2}, '{2, 0, 1}, '{0, 2, 1}, '{1, 2, 0}, '{1, 0, 2}, '{2, 1, 0},
        '{0, 1, 2}, '{0, 1, 2}};
    vic_top u_vic_top (.i_sys_clk, .i_rst, .i_bus(bq), .o_bus(rsp), .i_src_req(req),
        .i_src_clr(clr), .i_ei_exec(ei), .i_di_exec(di), .i_boot_reset(boot),
        .i_boot_vector(bvec), .i_cpu_accept(acc), .i_rom_data(rdat), .o_irq,
        .o_irq_level(lvl), .o_vector(vec), .o_rom_addr(raddr), .o_rom_rd(rrd),
        .o_svc_addr(svc), .o_svc_valid(sv), .o_reset_addr(rsta), .o_ext_tristate(ext));
    vic_cpu_model u_vic_cpu_model (.i_sys_clk, .i_rst, .i_delay(dly), .i_irq(o_irq),
        .i_rom_rd(rrd), .i_rom_addr(raddr), .i_svc_valid(sv), .o_accept(acc), .o_rom_data(rdat));
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // level rank key: group rank, then place in group, smaller wins
    function automatic int lkey(input logic [7:0] p, input int l);
        int g, n, pos;
        g = (l < 2) ? 0 : (l < 5) ? 1 : 2;
        n = (g == 0) ? 2 : 3;
        pos = l - ((g == 0) ? 0 : (g == 1) ? 2 : 5);
        if (p[3 + g]) pos = n - 1 - pos;
        return gr[p[2:0]][g] * 4 + pos;
    endfunction : lkey
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge i_sys_clk);
        bq <= '{a, !wr, wr, d};
        do begin
            @(posedge i_sys_clk);
            t++;
        end while (rsp.waitrequest !== 1'b0 && t < 50);
        rd = rsp.readdata;
        if (t >= 50) n_fail++;
        bq.read <= 1'b0;
        bq.write <= 1'b0;
    endtask : bus
    task automatic pulse(input logic c, input logic [23:0] s);
        @(posedge i_sys_clk);
        if (c) clr <= s;
        else req <= s;
        @(posedge i_sys_clk);
        clr <= 24'h0;
        req <= 24'h0;
    endtask : pulse
    task automatic ctl(input logic e, input logic d);
        @(posedge i_sys_clk);
        ei <= e;
        di <= d;
        @(posedge i_sys_clk);
        ei <= 1'b0;
        di <= 1'b0;
    endtask : ctl
    task automatic serve(input logic [7:0] v, input int l);
        int t;
        t = 0;
        while (o_irq !== 1'b1 && t < 60) begin
            @(posedge i_sys_clk);
            t++;
        end
        chk("vector", {24'h0, v}, {24'h0, vec});
        chk("level", l, {29'h0, lvl});
        while (sv !== 1'b1 && t < 90) begin
            @(posedge i_sys_clk);
            t++;
        end
        chk("service strobe", 1, {31'h0, sv});
        chk("service address", {16'h0, v ^ 8'hA5, (v + 8'h01) ^ 8'hA5}, {16'h0, svc});
    endtask : serve
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        #400000;
        n_fail++;
        print_verdict();
    end
    initial begin
        {i_rst, bq, req, clr, ei, di, boot, dly} = '0;
        i_rst = 1'b1;
        bvec = 16'h4321;
        seed = 56;
        repeat (6) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        chk("reset address", 32'h0100, {16'h0, rsta});
        bus(0, 4'hC, 0);
        chk("system mode", 0, rd);
        bus(1, 4'h0, 32'hA5);
        bus(0, 4'h0, 0);
        chk("mask", 32'hA5, rd);
        bus(1, 4'h4, 32'h2A);
        bus(0, 4'h4, 0);
        chk("priority", 32'h2A, rd);
        bus(1, 4'hC, 32'hFE);
        bus(0, 4'hC, 0);
        chk("system mode", 32'h9E, rd);
        chk("tristate", 0, {31'h0, ext});
        bus(1, 4'h8, 32'hFF);
        bus(0, 4'h8, 0);
        chk("pending", 0, rd);
        bus(0, 4'h2, 0);
        chk("unmapped", 0, rd);
        bus(1, 4'hC, 0);
        bus(1, 4'h0, 32'hFF);
        $display("register test done");
        pulse(0, 24'h10);
        repeat (8) @(posedge i_sys_clk);
        chk("irq before enable", 0, o_irq);
        ctl(1, 1);
        repeat (8) @(posedge i_sys_clk);
        chk("irq after disable", 0, o_irq);
        bus(1, 4'hC, 1);
        serve(8'hEC, 2);
        pulse(1, 24'h10);
        $display("enable test done");
        for (int s = 0; s < 23; s++) begin
            bus(1, 4'h0, 32'h1 << lv[s]);
            pulse(0, 24'h1 << s);
            bus(0, 4'h8, 0);
            chk("pending", 32'h1 << lv[s], rd);
            r = rnd();
            dly <= r[3:0];
            ctl(1, 0);
            serve(vt[s], lv[s]);
            bus(0, 4'h8, 0);
            chk("after service", (s == 1 || s == 3 || s == 6) ? 0 : 32'h1 << lv[s], rd);
            pulse(1, 24'h1 << s);
        end
        $display("source test done");
        for (int k = 0; k < 16; k++) begin
            r = rnd() | rnd();
            L = int'(r[26:24]);
            best = 256;
            for (int s = 0; s < 23; s++)
                if (r[s] && lv[s] == L && vt[s] < best) best = vt[s];
            bus(1, 4'h0, 32'h1 << L);
            pulse(0, r[23:0]);
            ctl(1, 0);
            if (best < 256) serve(best[7:0], L);
            else begin
                repeat (10) @(posedge i_sys_clk);
                chk("masked irq", 0, o_irq);
            end
            pulse(1, 24'hFFFFFF);
        end
        $display("priority test done");
        for (int k = 0; k < 12; k++) begin
            r = rnd();
            ia = int'(r[12:8]) % 23;
            ib = int'(r[20:16]) % 23;
            wl = (lkey(r[7:0], lv[ia]) <= lkey(r[7:0], lv[ib])) ? lv[ia] : lv[ib];
            wv = 256;
            if (lv[ia] == wl) wv = vt[ia];
            if (lv[ib] == wl && vt[ib] < wv) wv = vt[ib];
            bus(1, 4'h4, r);
            bus(1, 4'h0, 32'hFF);
            pulse(0, (24'h1 << ia) | (24'h1 << ib));
            ctl(1, 0);
            serve(wv[7:0], wl);
            pulse(1, 24'hFFFFFF);
        end
        $display("group test done");
        i_rst <= 1'b1;
        boot <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        chk("boot address", {16'h0, bvec}, {16'h0, rsta});
        $display("boot test done");
        print_verdict();
    end
endmodule : vectored_interrupt_controller_bench
